// [rtl/space_decode_pkg.sv]
`default_nettype none
package space_decode_pkg;
  // ---------------------------------------------------------------
  // address map
  // ---------------------------------------------------------------
  localparam logic [7:0] CTL_BASE = 8'h80;
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;
  localparam logic [7:0] STACK_RESET = 8'h07;
  localparam logic [7:0] ADDR_PORT0 = 8'h80;
  localparam logic [7:0] ADDR_STACK = 8'h81;
  localparam logic [7:0] ADDR_PORT1 = 8'h90;
  localparam logic [7:0] ADDR_SERIAL_CTRL = 8'h98;
  localparam logic [7:0] ADDR_SERIAL_DATA = 8'h99;
  localparam logic [7:0] ADDR_PORT2 = 8'ha0;
  localparam logic [7:0] ADDR_PORT3 = 8'hb0;
  localparam logic [7:0] PORT_RESET = 8'hff;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam int RAM_DEPTH = 256;
  localparam int UNASSIGNED_COUNT = 24;
  // ---------------------------------------------------------------
  // access kinds and access phases
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_DIRECT = 2'b00,
    ACC_INDIRECT = 2'b01,
    ACC_BIT = 2'b10,
    ACC_NONE = 2'b11
  } access_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MODIFY = 2'b01,
    ST_DONE = 2'b10
  } phase_e;

  // assigned register map: 104 of the 128 upper direct addresses
  function automatic logic ctl_assigned(input logic [7:0] a);
    logic [7:0] u;
    u = a;
    case (u[7:3])
      5'h12: ctl_assigned = (u[2:0] < 3'h6);
      5'h14: ctl_assigned = (u[2:0] != 3'h4);
      5'h16: ctl_assigned = (u[2:0] < 3'h5);
      5'h17: ctl_assigned = (u[2:0] == 3'h0);
      5'h18: ctl_assigned = (u[2:0] < 3'h2) || (u[2:0] == 3'h6);
      5'h19: ctl_assigned = (u[2:0] != 3'h1) && (u[2:0] != 3'h6) && (u[2:0] != 3'h7);
      5'h1e: ctl_assigned = (u[2:0] < 3'h3) || (u[2:0] > 3'h5);
      default: ctl_assigned = u[7];
    endcase
  endfunction
endpackage
`default_nettype wire

// [rtl/internal_ram.sv]
`default_nettype none
module internal_ram
  import space_decode_pkg::*;
(
  // clock
  input wire logic ref_clk_i,
  // access
  input wire logic we_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem_reg [RAM_DEPTH];
  // no reset: contents power up random
  always_ff @(posedge ref_clk_i) begin
    if (we_i) begin
      mem_reg[addr_i] <= wdata_i;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    rdata_o <= mem_reg[addr_i];
  end
endmodule
`default_nettype wire

// [rtl/space_decode.sv]
`default_nettype none
// How it works
// (RULE1) bit address n below 80h picks bit n mod 8 of byte 20h plus n/8
// (RULE2) bits and bytes 20h-2Fh share one RAM storage
// (RULE3) bit address 80h up picks bit n mod 8 of register n with low bits cleared
// (RULE4) bit set or clear changes only the addressed bit
// (RULE5) direct 00h-7Fh goes to RAM, 80h-FFh to registers
// (RULE6) upper RAM half is reached only by indirect access
// (RULE7) unassigned register reads give 00h, writes are dropped
// (RULE8) unassigned register addresses hold no storage
// (RULE9) 24 of the 128 upper direct addresses are unassigned
// (RULE10) bit operations only on registers at multiples of eight
// (RULE11) stack pointer resets to 07h
// (RULE12) bit 0 is least significant, bit 7 most significant
// (RULE13) direct write to 99h hands the byte to the serial port
// (RULE14) four port registers drive 32 lines, one bit each
// (RULE15) software keeps stack above 2Fh when using bit variables
// (RULE16) 256 bytes of internal RAM
// (RULE17) bit write is read-modify-write, bit read returns stored bit
module space_decode
  import space_decode_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // core request
  input wire logic req_i,
  input wire logic [1:0] kind_i,
  input wire logic we_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  // core answer
  output logic done_o,
  output logic [7:0] rdata_o,
  // peripheral side
  output logic [31:0] port_lines_o,
  output logic [7:0] stack_top_pointer_o,
  output logic [7:0] serial_data_buffer_o,
  output logic serial_load_o,
  output logic [7:0] serial_control_reg_o,
  output logic [7:0] spare_reg_o
);
  // ---------------------------------------------------------------
  // request capture
  // ---------------------------------------------------------------
  phase_e phase_reg;
  access_e kind_reg;
  logic we_reg;
  logic [7:0] addr_reg;
  logic [7:0] wdata_reg;
  logic busy;
  assign busy = (phase_reg != ST_IDLE);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      kind_reg <= ACC_NONE;
      we_reg <= 1'b0;
      addr_reg <= 8'h00;
      wdata_reg <= 8'h00;
    end else if (req_i && !busy) begin
      kind_reg <= access_e'(kind_i);
      we_reg <= we_i;
      addr_reg <= addr_i;
      wdata_reg <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_reg <= ST_IDLE;
    end else begin
      case (phase_reg)
        ST_IDLE: phase_reg <= (req_i && access_e'(kind_i) != ACC_NONE) ? ST_MODIFY : ST_IDLE;
        ST_MODIFY: phase_reg <= ST_DONE;
        ST_DONE: phase_reg <= ST_IDLE;
        default: phase_reg <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  // byte that holds the addressed bit, or the addressed byte itself
  function automatic logic [7:0] target_addr(input logic [1:0] k, input logic [7:0] a);
    if (k == ACC_BIT) begin
      // [RULE1] [RULE3]
      target_addr = a[7] ? {a[7:3], 3'h0} : BIT_RAM_BASE + {4'h0, a[6:3]};
    end else begin
      target_addr = a;
    end
  endfunction

  logic to_ram;
  logic [7:0] byte_addr;
  logic [2:0] bit_sel;
  logic bit_ok;
  always_comb begin
    bit_sel = addr_reg[2:0]; // [RULE12]
    bit_ok = 1'b1;
    byte_addr = target_addr(kind_reg, addr_reg);
    case (kind_reg)
      ACC_INDIRECT: begin
        to_ram = 1'b1; // [RULE6]
      end
      ACC_BIT: begin
        to_ram = !addr_reg[7];
        // [RULE10] only aligned registers ever see a bit op
        bit_ok = addr_reg[7] ? ctl_assigned({addr_reg[7:3], 3'h0}) : 1'b1;
      end
      default: begin
        to_ram = (addr_reg < CTL_BASE); // [RULE5]
      end
    endcase
  end

  // ---------------------------------------------------------------
  // ram and registers
  // ---------------------------------------------------------------
  logic [7:0] ram_q;
  logic ram_we;
  logic [7:0] old_byte;
  logic [7:0] new_byte;
  logic [7:0] ctl_q;
  logic ctl_hit;
  logic [7:0] ram_addr;
  // idle: look up the incoming target now, so the modify cycle
  // sees the stored byte and not the one of the previous access
  assign ram_addr = (phase_reg == ST_IDLE) ? target_addr(kind_i, addr_i) : byte_addr;
  assign ram_we = (phase_reg == ST_MODIFY) && we_reg && to_ram;
  internal_ram u_ram ( // [RULE16] [RULE2]
    .ref_clk_i(ref_clk_i),
    .we_i(ram_we),
    .addr_i(ram_addr),
    .wdata_i(new_byte),
    .rdata_o(ram_q)
  );

  logic [7:0] port_reg [4];
  logic [7:0] stack_reg;
  logic [7:0] serial_data_reg;
  logic [7:0] serial_ctrl_reg;
  logic [7:0] spare_reg;
  logic ctl_we;
  assign ctl_hit = ctl_assigned(byte_addr); // [RULE9] [RULE8]

  always_comb begin
    case (byte_addr)
      ADDR_PORT0: ctl_q = port_reg[0];
      ADDR_PORT1: ctl_q = port_reg[1];
      ADDR_PORT2: ctl_q = port_reg[2];
      ADDR_PORT3: ctl_q = port_reg[3];
      ADDR_STACK: ctl_q = stack_reg;
      ADDR_SERIAL_DATA: ctl_q = serial_data_reg;
      ADDR_SERIAL_CTRL: ctl_q = serial_ctrl_reg;
      default: ctl_q = ctl_hit ? spare_reg : READ_ZERO; // [RULE7]
    endcase
  end

  // [RULE17] bit write merges into the current byte
  assign old_byte = to_ram ? ram_q : ctl_q;
  always_comb begin
    new_byte = wdata_reg;
    if (kind_reg == ACC_BIT) begin
      new_byte = old_byte;
      new_byte[bit_sel] = wdata_reg[0]; // [RULE4]
    end
  end

  assign ctl_we = (phase_reg == ST_MODIFY) && we_reg && !to_ram && ctl_hit && bit_ok;

  // one latch per port, 32 lines in total
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_port
      always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          port_reg[g] <= PORT_RESET;
        // port latches sit 10h apart from the first one
        end else if (ctl_we && byte_addr == ADDR_PORT0 + {2'h0, 2'(g), 4'h0}) begin
          port_reg[g] <= new_byte; // [RULE14]
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stack_reg <= STACK_RESET; // [RULE11]
      serial_data_reg <= 8'h00;
      serial_ctrl_reg <= 8'h00;
      spare_reg <= 8'h00;
      serial_load_o <= 1'b0;
    end else begin
      serial_load_o <= ctl_we && byte_addr == ADDR_SERIAL_DATA; // [RULE13]
      if (ctl_we) begin
        case (byte_addr)
          ADDR_STACK: stack_reg <= new_byte;
          ADDR_SERIAL_DATA: serial_data_reg <= new_byte;
          ADDR_SERIAL_CTRL: serial_ctrl_reg <= new_byte;
          ADDR_PORT0, ADDR_PORT1, ADDR_PORT2, ADDR_PORT3: spare_reg <= spare_reg;
          default: spare_reg <= new_byte;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // answer
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_o <= 1'b0;
      rdata_o <= 8'h00;
    end else begin
      done_o <= (phase_reg == ST_MODIFY);
      if (phase_reg == ST_MODIFY) begin
        if (kind_reg == ACC_BIT) begin
          rdata_o <= {7'h00, bit_ok ? old_byte[bit_sel] : 1'b0}; // [RULE17]
        end else begin
          rdata_o <= old_byte;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_lines_o <= {4{PORT_RESET}};
      stack_top_pointer_o <= STACK_RESET;
      serial_data_buffer_o <= 8'h00;
      serial_control_reg_o <= 8'h00;
      spare_reg_o <= 8'h00;
    end else begin
      port_lines_o <= {port_reg[3], port_reg[2], port_reg[1], port_reg[0]};
      stack_top_pointer_o <= stack_reg;
      serial_data_buffer_o <= serial_data_reg;
      serial_control_reg_o <= serial_ctrl_reg;
      spare_reg_o <= spare_reg;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  unassigned_read_a: assert property ( // [RULE7]
    phase_reg == ST_MODIFY && !to_ram && !ctl_hit && kind_reg != ACC_BIT |=> rdata_o == 8'h00)
    else $error("unassigned read not zero");
  serial_load_a: assert property ( // [RULE13]
    phase_reg == ST_MODIFY && we_reg && kind_reg == ACC_DIRECT && addr_reg == 8'h99
    |=> serial_load_o ##1 serial_data_buffer_o == $past(wdata_reg, 2))
    else $error("serial load missing");
  done_timing_a: assert property (
    req_i && !busy && kind_i != 2'b11 |-> ##2 done_o)
    else $error("done late");
  direct_route_a: assert property ( // [RULE5]
    kind_reg == ACC_DIRECT |-> to_ram == !addr_reg[7])
    else $error("direct routing wrong");
  indirect_ram_a: assert property ( // [RULE6]
    kind_reg == ACC_INDIRECT |-> to_ram && byte_addr == addr_reg)
    else $error("indirect not to ram");
  bit_ram_map_a: assert property ( // [RULE1]
    kind_reg == ACC_BIT && !addr_reg[7] |-> byte_addr == 8'h20 + addr_reg[6:3])
    else $error("bit ram map wrong");
  bit_only_a: assert property ( // [RULE4]
    phase_reg == ST_MODIFY && kind_reg == ACC_BIT && we_reg && !to_ram && bit_ok
    && addr_reg[7:3] == 5'h10 |=> ##1 (port_lines_o[7:0] ^ $past(old_byte, 2))
    == (8'h01 << $past(bit_sel, 2)) || port_lines_o[7:0] == $past(old_byte, 2))
    else $error("bit op touched other bits");
  bit_ctl_align_a: assert property ( // [RULE10]
    kind_reg == ACC_BIT && addr_reg[7] |-> byte_addr[2:0] == 3'h0)
    else $error("bit op on unaligned register");
  stack_reset_a: assert property ( // [RULE11]
    $rose(rst_n_i) |-> stack_reg == 8'h07)
    else $error("stack reset wrong");

  bit_cov_c: cover property (phase_reg == ST_MODIFY && kind_reg == ACC_BIT && we_reg);
  ctl_cov_c: cover property (ctl_we && byte_addr == ADDR_SERIAL_DATA);
  miss_cov_c: cover property (phase_reg == ST_MODIFY && !to_ram && !ctl_hit);
  ind_cov_c: cover property (ram_we && kind_reg == ACC_INDIRECT && addr_reg[7]);
endmodule
`default_nettype wire

// [test/core_model.sv]
`default_nettype none
module core_model
  import space_decode_pkg::*;
(
  // clock
  input wire logic clk_i,
  // request
  output var logic req_o,
  output var logic [1:0] kind_o,
  output var logic we_o,
  output var logic [7:0] addr_o,
  output var logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req_o = 1'b0;
    kind_o = ACC_NONE;
    we_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // ---------------------------------------------------------------
  // one access, entered at a falling edge, three cycles long
  // ---------------------------------------------------------------
  task automatic access(input access_e k, input logic w, input logic [7:0] a,
                        input logic [7:0] d);
    req_o = 1'b1;
    kind_o = k;
    we_o = w;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    req_o = 1'b0;
    kind_o = ACC_NONE;
    // released lines flip so a stale value never looks valid
    addr_o = ~a;
    wdata_o = ~d;
    repeat (2) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// [test/space_decode_test.sv]
`default_nettype none
module space_decode_test
  import space_decode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i, rst_n_i, req_i, we_i, done_o, serial_load_o;
  logic [1:0] kind_i;
  logic [7:0] addr_i, wdata_i, rdata_o, stack_top_pointer_o, serial_data_buffer_o;
  logic [7:0] serial_control_reg_o, spare_reg_o, a, d, n;
  logic [31:0] port_lines_o;
  logic [2:0] b;
  logic [8:0] e;
  logic [8:0] exp_q[$];
  logic [7:0] regs[5] = '{ADDR_PORT0, ADDR_PORT1, ADDR_PORT2, ADDR_PORT3, ADDR_SERIAL_CTRL};
  int fails, n_tests, loads;
  space_decode i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
    .kind_i(kind_i), .we_i(we_i), .addr_i(addr_i), .wdata_i(wdata_i), .done_o(done_o),
    .rdata_o(rdata_o), .port_lines_o(port_lines_o), .stack_top_pointer_o(stack_top_pointer_o),
    .serial_data_buffer_o(serial_data_buffer_o), .serial_load_o(serial_load_o),
    .serial_control_reg_o(serial_control_reg_o), .spare_reg_o(spare_reg_o));
  core_model i_core (.clk_i(ref_clk_i), .req_o(req_i), .kind_o(kind_i), .we_o(we_i),
    .addr_o(addr_i), .wdata_o(wdata_i));
  // ---------------------------------------------------------------
  // compare and access helpers
  // ---------------------------------------------------------------
  function automatic logic unassigned(input logic [7:0] x);
    return x inside {8'h96, 8'h97, 8'ha4, [8'hb5:8'hb7], [8'hb9:8'hbf], [8'hc2:8'hc5],
                     8'hc7, 8'hc9, 8'hce, 8'hcf, [8'hf3:8'hf5]};
  endfunction
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t output %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_rd(input logic [7:0] exp);
    n_tests++;
    if (rdata_o !== exp) begin
      fails++;
      $display("[ERR] %0t read %h expected %h", $time, rdata_o, exp);
    end
  endtask
  task automatic wr(input access_e k, input logic [7:0] x, input logic [7:0] v);
    exp_q.push_back({1'b0, 8'h00});
    i_core.access(k, 1'b1, x, v);
  endtask
  task automatic rd(input access_e k, input logic [7:0] x, input logic [7:0] v);
    exp_q.push_back({1'b1, v});
    i_core.access(k, 1'b0, x, 8'h00);
  endtask
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(negedge ref_clk_i) begin
    if (serial_load_o === 1'b1) loads++;
    if (done_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("[ERR] %0t answer without request", $time);
      end else begin
        e = exp_q.pop_front();
        if (e[8]) cmp_rd(e[7:0]);
      end
    end
  end
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  // budget far above the roughly 1330 cycles the tests need
  initial begin
    #(20 * 20000);
    fails++;
    complete_run();
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    rst_n_i = 1'b0;
    void'($urandom(32'h4a99af2e));
    repeat (10) @(negedge ref_clk_i);
    check8(stack_top_pointer_o, STACK_RESET);
    for (int p = 0; p < 4; p++) check8(port_lines_o[p*8+:8], PORT_RESET);
    rst_n_i = 1'b1;
    @(negedge ref_clk_i);
    for (int i = 0; i < 8; i++) begin
      a = 8'($urandom_range(8'h30, 8'h7f));
      d = 8'($urandom);
      wr(ACC_DIRECT, a, d);
      rd(ACC_INDIRECT, a, d);
    end
    wr(ACC_INDIRECT, 8'hff, 8'h96);
    wr(ACC_INDIRECT, ADDR_PORT1, 8'h3c);
    wr(ACC_DIRECT, ADDR_PORT1, 8'hc3);
    rd(ACC_INDIRECT, ADDR_PORT1, 8'h3c);
    rd(ACC_DIRECT, ADDR_PORT1, 8'hc3);
    rd(ACC_INDIRECT, 8'hff, 8'h96);
    check8(port_lines_o[15:8], 8'hc3);
    $display("test 1 done");
    wr(ACC_DIRECT, ADDR_STACK, 8'h30); // stack kept clear of bit bytes
    rd(ACC_DIRECT, ADDR_STACK, 8'h30);
    for (int i = 0; i < 16; i++) begin
      b = 3'($urandom);
      a = BIT_RAM_BASE + 8'(i);
      n = {1'b0, i[3:0], b};
      wr(ACC_DIRECT, a, 8'h00);
      wr(ACC_BIT, n, 8'h01);
      rd(ACC_DIRECT, a, 8'h01 << b);
      wr(ACC_DIRECT, a, 8'hff);
      wr(ACC_BIT, n, 8'h00);
      rd(ACC_DIRECT, a, ~(8'h01 << b));
      rd(ACC_BIT, n, 8'h00);
      rd(ACC_BIT, n ^ 8'h01, 8'h01);
    end
    $display("test 2 done");
    for (int p = 0; p < 5; p++) begin
      b = 3'($urandom);
      wr(ACC_DIRECT, regs[p], 8'h00);
      wr(ACC_BIT, regs[p] | 8'(b), 8'h01);
      @(negedge ref_clk_i);
      check8(p < 4 ? port_lines_o[p*8+:8] : serial_control_reg_o, 8'h01 << b);
      rd(ACC_BIT, regs[p] | 8'(b), 8'h01);
      wr(ACC_DIRECT, regs[p], 8'hff);
      wr(ACC_BIT, regs[p] | 8'(b), 8'h00);
      @(negedge ref_clk_i);
      check8(p < 4 ? port_lines_o[p*8+:8] : serial_control_reg_o, ~(8'h01 << b));
    end
    $display("test 3 done");
    d = 8'($urandom);
    loads = 0;
    wr(ACC_DIRECT, ADDR_SERIAL_DATA, d);
    repeat (3) @(negedge ref_clk_i);
    check8(serial_data_buffer_o, d);
    check8(8'(loads), 8'h01);
    $display("test 4 done");
    for (int i = 128; i < 256; i++) wr(ACC_DIRECT, 8'(i), unassigned(8'(i)) ? 8'ha5 : 8'h5a);
    for (int i = 128; i < 256; i++) begin
      rd(ACC_DIRECT, 8'(i), unassigned(8'(i)) ? 8'h00 : 8'h5a);
    end
    check8(spare_reg_o, 8'h5a);
    check8(stack_top_pointer_o, 8'h5a);
    $display("test 5 done");
    repeat (4) @(negedge ref_clk_i);
    check8(8'(exp_q.size()), 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
